// ===== src/port_mac_cfg_regs.vh
// register map, field positions, reset values and timing counts
// for the external port interface and switch mac configuration block
`ifndef PORT_MAC_CFG_REGS_VH
`define PORT_MAC_CFG_REGS_VH

// register indices; byte address on the bus is four times the index
`define IDX_PORT_SPEED_DUPLEX 11'h300
`define IDX_PORT_INTERFACE_CONFIG 11'h301
`define IDX_PORT_MAC_CONTROL_A 11'h400
`define IDX_PORT_MAC_CONTROL_B 11'h401
`define IDX_PORT_STATUS 11'h4f0

// port_speed_duplex fields
`define BIT_FULL_DUPLEX 6
`define BIT_SPEED_100 4
`define RST_SPEED_DUPLEX 8'h50

// port_interface_config fields
`define BIT_SPEED_SEL 6
`define BIT_RX_SKEW 4
`define BIT_TX_SKEW 3
`define BIT_CLOCK_ROLE 2
`define BIT_TYPE_HI 1
`define BIT_TYPE_LO 0
`define RW_MASK_IFCFG 8'hff
`define RST_IFCFG 8'h08

// port_mac_control_a fields
`define BIT_STORM_PROTECT 1
`define BIT_JUMBO 0
`define RW_MASK_MAC_A 8'h0b
`define RST_MAC_A 8'h00

// port_mac_control_b fields
`define BIT_BACK_PRESSURE 3
`define BIT_PASS_ALL 0
`define RW_MASK_MAC_B 8'hbf
`define RST_MAC_B 8'h00

// interface type codes
`define TYPE_RGMII 2'h0
`define TYPE_RMII 2'h1

// payload limits in bytes
`define PAYLOAD_STD 14'h05dc
`define PAYLOAD_JUMBO 14'h2328
`define PAYLOAD_MIN 14'h002e

// link clock watchdog, in clk cycles (link clock is far slower)
`define LINK_TIMEOUT_CYCLES 8'h40

`endif

// ===== src/port_mac_cfg.v
// per-port external interface and switch mac configuration block
// assumes an avalon-mm master on clk, straps and link clock pin from
// outside the clk domain, frame status inputs from mac logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "port_mac_cfg_regs.vh"

// Summary of operation
// - type field 00 is rgmii, 01 is rmii, 10 and 11 are mii.
// - type, role and speed-1000 work on port 6 only; strap defaults there.
// - speed select zero gives 1000 Mb/s; one gives 10/100 per speed bit.
// - outside 1000 mode, speed bit one gives 100, zero gives 10 Mb/s.
// - in mii, role bit one acts as mac taking clocks; zero drives them.
// - in rmii, role bit one takes 50 MHz ref in; zero drives it out.
// - rx skew bit adds at least 1.5 ns to received clock; resets zero.
// - tx skew bit adds at least 1.5 ns to sent clock; resets one.
// - jumbo allows 9000 payload bytes, else 1500.
// - control a bit 1 enables broadcast storm protection; resets off.
// - back pressure acts only in half duplex; pause frames separate.
// - bad frames dropped; pass-all forwards them for mirroring only.
// - pass-all leaves flow control frame filtering unchanged.
module port_mac_cfg #(
   parameter PORT_NUM = 6 // 6 has the configurable interface
) (
   input wire clk, // 40 mhz switch clock
   input wire sys_rst, // synchronous reset, active high
   input wire [12:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output reg [31:0] avs_readdata, // read data
   output wire avs_waitrequest, // stall while high
   input wire speed_strap_pin, // strap for speed select
   input wire clock_role_strap_pin, // strap for mii/rmii role
   input wire [1:0] interface_type_strap_pins, // strap for type
   input wire receive_clock_pin_in, // receive clock pin level
   output wire receive_clock_pin_out, // receive clock pin drive
   output reg receive_clock_pin_oe, // receive clock pin enable
   input wire reduced_interface_ref_clock, // 50 mhz source to drive
   input wire frame_busy, // a frame is in progress
   input wire rx_frame_end, // pulse, received frame complete
   input wire rx_crc_error, // with rx_frame_end
   input wire [13:0] rx_payload_len, // with rx_frame_end
   input wire rx_is_flow_ctrl, // with rx_frame_end, pause frame
   input wire flow_ctrl_filter_en, // switch-level pause filtering
   output reg mode_rgmii, // active interface is rgmii
   output reg mode_rmii, // active interface is rmii
   output reg mode_mii, // active interface is mii
   output reg speed_1000, // running at 1000 mb/s
   output reg speed_100, // running at 100 mb/s
   output reg speed_10, // running at 10 mb/s
   output reg mii_clock_out_en, // mii phy role drives clocks
   output reg rx_clock_skew_enable, // delay on received clock
   output reg tx_clock_skew_enable, // delay on sent clock
   output reg [13:0] max_payload, // accepted payload limit
   output reg storm_protect_en, // broadcast storm protection
   output reg back_pressure_active, // half duplex back pressure
   output reg frame_forward, // pulse, frame passes normally
   output reg frame_mirror_only, // pulse, bad frame kept for mirror
   output reg frame_drop, // pulse, frame discarded
   output reg link_clock_alive // link clock edges seen lately
);

   // only the configurable port honours the type, role and speed straps
   localparam IS_CFG_PORT = (PORT_NUM == 6);

   // software registers
   reg [7:0] speed_duplex;
   reg [7:0] ifcfg;
   reg [7:0] mac_a;
   reg [7:0] mac_b;
   // settings in force on the link
   reg [1:0] act_type;
   reg act_speed_sel;
   reg act_speed100;
   reg act_jumbo;
   // bus handshake
   reg ack;
   wire req;
   wire [10:0] idx;
   wire [7:0] wbyte;
   wire wr_en;
   // synchronisers
   reg [3:0] strap_s1;
   reg [3:0] strap_s2;
   reg rxc_s1;
   reg rxc_s2;
   reg rxc_s3;
   reg [7:0] idle_cnt;
   wire pending;
   wire bad_frame;
   wire [13:0] limit;

   // interface type decode, shared by the mode outputs and the pin drivers
   function is_rmii;
      input [1:0] t; // interface type code
      begin
         is_rmii = (t == `TYPE_RMII);
      end
   endfunction

   // both upper codes select mii, so only the high bit matters
   function is_mii;
      input [1:0] t; // interface type code
      begin
         is_mii = t[1];
      end
   endfunction

   // one wait cycle, then the request completes; every request costs
   // exactly two cycles, which keeps the read path to one registered mux
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign idx = avs_address[12:2];
   assign wbyte = avs_writedata[7:0];
   assign wr_en = avs_write & ack & avs_byteenable[0];

   always @(posedge clk)
   begin
      if (sys_rst)
         ack <= 1'b0;
      else
         ack <= req & ~ack;
   end

   // straps pass two flops before use; they are loaded on every reset
   // edge, so reset must stand at least three cycles for settled values
   always @(posedge clk)
   begin
      strap_s1 <= {speed_strap_pin, clock_role_strap_pin,
                   interface_type_strap_pins};
      strap_s2 <= strap_s1;
   end

   // register writes; straps load the port 6 fields during reset
   // a write with byte lane 0 off changes nothing; upper lanes are unused
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         speed_duplex <= `RST_SPEED_DUPLEX;
         ifcfg <= `RST_IFCFG;
         mac_a <= `RST_MAC_A;
         mac_b <= `RST_MAC_B;
         if (IS_CFG_PORT)
         begin
            ifcfg[`BIT_SPEED_SEL] <= strap_s2[3];
            ifcfg[`BIT_CLOCK_ROLE] <= strap_s2[2];
            ifcfg[`BIT_TYPE_HI:`BIT_TYPE_LO] <= strap_s2[1:0];
         end
      end
      else if (wr_en)
      begin
         case (idx)
            `IDX_PORT_SPEED_DUPLEX:
            begin
               speed_duplex[`BIT_FULL_DUPLEX] <= wbyte[`BIT_FULL_DUPLEX];
               speed_duplex[`BIT_SPEED_100] <= wbyte[`BIT_SPEED_100];
            end
            `IDX_PORT_INTERFACE_CONFIG:
            begin
               ifcfg <= wbyte & `RW_MASK_IFCFG;
               if (!IS_CFG_PORT)
               begin
                  ifcfg[`BIT_SPEED_SEL] <= 1'b0;
                  ifcfg[`BIT_CLOCK_ROLE] <= 1'b0;
                  ifcfg[`BIT_TYPE_HI:`BIT_TYPE_LO] <= 2'h0;
               end
            end
            `IDX_PORT_MAC_CONTROL_A:
               mac_a <= wbyte & `RW_MASK_MAC_A;
            `IDX_PORT_MAC_CONTROL_B:
               mac_b <= wbyte & `RW_MASK_MAC_B;
            default:
               mac_b <= mac_b;
         endcase
      end
   end

   // read data, unmapped addresses read zero
   // the status word gathers live state and never changes a setting
   always @(posedge clk)
   begin
      if (sys_rst)
         avs_readdata <= 32'h00000000;
      else if (avs_read & ~ack)
      begin
         case (idx)
            `IDX_PORT_SPEED_DUPLEX:
               avs_readdata <= {24'h000000, speed_duplex};
            `IDX_PORT_INTERFACE_CONFIG:
               avs_readdata <= {24'h000000, ifcfg};
            `IDX_PORT_MAC_CONTROL_A:
               avs_readdata <= {24'h000000, mac_a};
            `IDX_PORT_MAC_CONTROL_B:
               avs_readdata <= {24'h000000, mac_b};
            `IDX_PORT_STATUS:
               avs_readdata <= {24'h000000, link_clock_alive, pending,
                                speed_1000, speed_100, speed_10,
                                act_jumbo, act_type};
            default:
               avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // new settings wait until no frame is in progress
   assign pending = (act_type != ifcfg[`BIT_TYPE_HI:`BIT_TYPE_LO]) |
                    (act_speed_sel != ifcfg[`BIT_SPEED_SEL]) |
                    (act_speed100 != speed_duplex[`BIT_SPEED_100]) |
                    (act_jumbo != mac_a[`BIT_JUMBO]);

   // type, speed and frame size move only while no frame is in progress;
   // a frame_busy stuck high therefore freezes these settings, which the
   // status pending bit lets software see
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         act_type <= `TYPE_RGMII;
         act_speed_sel <= 1'b0;
         act_speed100 <= 1'b1;
         act_jumbo <= 1'b0;
      end
      else if (~frame_busy)
      begin
         act_type <= ifcfg[`BIT_TYPE_HI:`BIT_TYPE_LO];
         act_speed_sel <= ifcfg[`BIT_SPEED_SEL];
         act_speed100 <= speed_duplex[`BIT_SPEED_100];
         act_jumbo <= mac_a[`BIT_JUMBO];
      end
   end

   // decoded mode, speed and clock direction outputs
   // skew, role, storm and back pressure follow the registers at once,
   // since they cannot cut a frame in two
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         mode_rgmii <= 1'b1;
         mode_rmii <= 1'b0;
         mode_mii <= 1'b0;
         speed_1000 <= 1'b1;
         speed_100 <= 1'b0;
         speed_10 <= 1'b0;
         mii_clock_out_en <= 1'b0;
         receive_clock_pin_oe <= 1'b0;
         rx_clock_skew_enable <= 1'b0;
         tx_clock_skew_enable <= 1'b1;
         max_payload <= `PAYLOAD_STD;
         storm_protect_en <= 1'b0;
         back_pressure_active <= 1'b0;
      end
      else
      begin
         mode_rgmii <= (act_type == `TYPE_RGMII);
         mode_rmii <= is_rmii(act_type);
         mode_mii <= is_mii(act_type);
         speed_1000 <= ~act_speed_sel;
         speed_100 <= act_speed_sel & act_speed100;
         speed_10 <= act_speed_sel & ~act_speed100;
         mii_clock_out_en <= is_mii(act_type) & ~ifcfg[`BIT_CLOCK_ROLE];
         receive_clock_pin_oe <= is_rmii(act_type) &
                                 ~ifcfg[`BIT_CLOCK_ROLE];
         rx_clock_skew_enable <= ifcfg[`BIT_RX_SKEW];
         tx_clock_skew_enable <= ifcfg[`BIT_TX_SKEW];
         max_payload <= limit;
         storm_protect_en <= mac_a[`BIT_STORM_PROTECT];
         back_pressure_active <= mac_b[`BIT_BACK_PRESSURE] &
                                 ~speed_duplex[`BIT_FULL_DUPLEX];
      end
   end

   // rmii reference clock driven out when the block sources it
   // the pad delay cells sit outside; only their enables come from here
   assign receive_clock_pin_out = reduced_interface_ref_clock;

   // frame verdict at the end of each received frame
   // priority: filtered pause frame, good frame, pass-all mirror, drop
   // bad means crc error, payload above the limit or below the minimum
   assign limit = act_jumbo ? `PAYLOAD_JUMBO : `PAYLOAD_STD;
   assign bad_frame = rx_crc_error | (rx_payload_len > limit) |
                      (rx_payload_len < `PAYLOAD_MIN);

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         frame_forward <= 1'b0;
         frame_mirror_only <= 1'b0;
         frame_drop <= 1'b0;
      end
      else
      begin
         frame_forward <= 1'b0;
         frame_mirror_only <= 1'b0;
         frame_drop <= 1'b0;
         if (rx_frame_end)
         begin
            if (rx_is_flow_ctrl & flow_ctrl_filter_en)
               frame_drop <= 1'b1;
            else if (~bad_frame)
               frame_forward <= 1'b1;
            else if (mac_b[`BIT_PASS_ALL])
               frame_mirror_only <= 1'b1;
            else
               frame_drop <= 1'b1;
         end
      end
   end

   // link clock sampled by clk; watchdog on its rising edges
   // the third flop only serves edge detection; the idle count saturates
   // at the timeout so it never wraps back into the alive window
   always @(posedge clk)
   begin
      rxc_s1 <= receive_clock_pin_in;
      rxc_s2 <= rxc_s1;
      rxc_s3 <= rxc_s2;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         idle_cnt <= `LINK_TIMEOUT_CYCLES;
         link_clock_alive <= 1'b0;
      end
      else if (rxc_s2 & ~rxc_s3)
      begin
         idle_cnt <= 8'h00;
         link_clock_alive <= 1'b1;
      end
      else if (idle_cnt != `LINK_TIMEOUT_CYCLES)
         idle_cnt <= idle_cnt + 8'h01;
      else
         link_clock_alive <= 1'b0;
   end

endmodule // port_mac_cfg
`default_nettype wire

// ===== sim/port_mac_cfg_props.sv
// assertion checker for the port interface and mac configuration block
// assumes a single clk domain with synchronous active high sys_rst
`timescale 1ns/1ps
`default_nettype none
module port_mac_cfg_props (
   input wire logic clk, // clock
   input wire logic sys_rst, // reset
   input wire logic avs_read, // bus read
   input wire logic avs_write, // bus write
   input wire logic avs_waitrequest, // bus stall
   input wire logic frame_busy, // frame in progress
   input wire logic rx_frame_end, // frame end pulse
   input wire logic rx_crc_error, // crc flag
   input wire logic [13:0] rx_payload_len, // payload length
   input wire logic rx_is_flow_ctrl, // pause frame
   input wire logic flow_ctrl_filter_en, // pause filter
   input wire logic mode_rgmii, // type outputs
   input wire logic mode_rmii, // type outputs
   input wire logic mode_mii, // type outputs
   input wire logic speed_1000, // speed outputs
   input wire logic speed_100, // speed outputs
   input wire logic speed_10, // speed outputs
   input wire logic [13:0] max_payload, // payload limit
   input wire logic frame_forward, // verdict
   input wire logic frame_mirror_only, // verdict
   input wire logic frame_drop // verdict
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // bus timing, decoded modes, limits and frame verdicts
   property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus stall longer than one cycle");
   property p_mode_hot; $onehot({mode_rgmii, mode_rmii, mode_mii}); endproperty
   a_mode_hot: assert property (p_mode_hot) else $error("interface mode not one-hot");
   property p_speed_hot; $onehot({speed_1000, speed_100, speed_10}); endproperty
   a_speed_hot: assert property (p_speed_hot) else $error("speed not one-hot");
   property p_limit; max_payload == 14'h05dc || max_payload == 14'h2328; endproperty
   a_limit: assert property (p_limit) else $error("payload limit not 1500 or 9000");
   property p_one_verdict; rx_frame_end |=> $onehot({frame_forward, frame_mirror_only, frame_drop}); endproperty
   a_one_verdict: assert property (p_one_verdict) else $error("frame without one verdict");
   property p_no_verdict; !rx_frame_end |=> !(frame_forward || frame_mirror_only || frame_drop); endproperty
   a_no_verdict: assert property (p_no_verdict) else $error("verdict without frame");
   property p_crc_block; rx_frame_end && rx_crc_error |=> !frame_forward; endproperty
   a_crc_block: assert property (p_crc_block) else $error("crc error frame forwarded");
   property p_long_block; rx_frame_end && rx_payload_len > max_payload |=> !frame_forward; endproperty
   a_long_block: assert property (p_long_block) else $error("oversized frame forwarded");
   property p_fc_drop; rx_frame_end && rx_is_flow_ctrl && flow_ctrl_filter_en |=> frame_drop; endproperty
   a_fc_drop: assert property (p_fc_drop) else $error("filtered pause frame not dropped");
   property p_busy_hold; frame_busy [*2] |=> $stable(max_payload) && $stable(mode_rgmii); endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("setting changed in a frame");
endmodule // port_mac_cfg_props
bind port_mac_cfg port_mac_cfg_props u_props (.clk, .sys_rst, .avs_read, .avs_write,
   .avs_waitrequest, .frame_busy, .rx_frame_end, .rx_crc_error, .rx_payload_len,
   .rx_is_flow_ctrl, .flow_ctrl_filter_en, .mode_rgmii, .mode_rmii, .mode_mii, .speed_1000,
   .speed_100, .speed_10, .max_payload, .frame_forward, .frame_mirror_only, .frame_drop);
`default_nettype wire

// ===== sim/link_phy_model.sv
// far-side phy model that drives the receive clock pin
// assumes the block's pin enable and value are handed in from the bench
`timescale 1ns/1ps
`default_nettype none
module link_phy_model (
   input wire logic run, // link clock toggles while high
   input wire logic dut_oe, // block drives the pin
   input wire logic dut_out, // block pin value
   output wire logic pin // resolved pin level
);
   logic lclk = 1'b0;
   // 200 ns link clock, standing still when stopped
   initial forever #100 if (run) lclk = ~lclk;
   // block's reference clock wins while its enable is high
   assign pin = dut_oe ? dut_out : lclk;
endmodule // link_phy_model
`default_nettype wire

// ===== sim/switch_port_mac_interface_config_bench.sv
// self-checking bench for the port interface and mac configuration block
// assumes port 6 straps: speed select 1, role 0, type rmii
`timescale 1ns/1ps
`default_nettype none
module switch_port_mac_interface_config_bench;
   logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, run = 1'b1;
   logic [12:0] avs_address = 13'h0000;
   logic [31:0] avs_writedata = 32'h0, q;
   logic reduced_interface_ref_clock = 1'b0, frame_busy = 1'b0, rx_frame_end = 1'b0;
   logic rx_crc_error = 1'b0, rx_is_flow_ctrl = 1'b0, flow_ctrl_filter_en = 1'b0;
   logic [13:0] rx_payload_len = 14'h0040;
   wire [31:0] avs_readdata;
   wire [13:0] max_payload;
   wire avs_waitrequest, receive_clock_pin_in, receive_clock_pin_out, receive_clock_pin_oe;
   wire mode_rgmii, mode_rmii, mode_mii, speed_1000, speed_100, speed_10, mii_clock_out_en;
   wire rx_clock_skew_enable, tx_clock_skew_enable, storm_protect_en, back_pressure_active;
   wire frame_forward, frame_mirror_only, frame_drop, link_clock_alive;
   int n_mismatch = 0, num_checks = 0, cyc = 0, i;
   port_mac_cfg DUT (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .speed_strap_pin(1'b1),
      .clock_role_strap_pin(1'b0), .interface_type_strap_pins(2'h1), .receive_clock_pin_in,
      .receive_clock_pin_out, .receive_clock_pin_oe, .reduced_interface_ref_clock, .frame_busy,
      .rx_frame_end, .rx_crc_error, .rx_payload_len, .rx_is_flow_ctrl, .flow_ctrl_filter_en,
      .mode_rgmii, .mode_rmii, .mode_mii, .speed_1000, .speed_100, .speed_10, .mii_clock_out_en,
      .rx_clock_skew_enable, .tx_clock_skew_enable, .max_payload, .storm_protect_en,
      .back_pressure_active, .frame_forward, .frame_mirror_only, .frame_drop, .link_clock_alive);
   link_phy_model phy (.run, .dut_oe(receive_clock_pin_oe), .dut_out(receive_clock_pin_out),
      .pin(receive_clock_pin_in));
   // 40 mhz clock and 50 mhz reference source
   initial forever #12.5 clk = ~clk;
   initial forever #10 reduced_interface_ref_clock = ~reduced_interface_ref_clock;
   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      begin
         num_checks++;
         if (s !== e)
         begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   // one bus cycle held until waitrequest is sampled low at a rising edge,
   // then a few cycles for the outputs to follow
   task bus(input logic w, input logic [12:0] a, input logic [7:0] d);
      begin
         @(posedge clk);
         avs_address <= a;
         avs_read <= ~w;
         avs_write <= w;
         avs_writedata <= {24'h0, d};
         @(posedge clk);
         while (avs_waitrequest !== 1'b0)
            @(posedge clk);
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task rdc(input logic [12:0] a, input logic [7:0] e);
      begin
         bus(1'b0, a, 8'h00);
         chk(q, {24'h0, e});
      end
   endtask
   // one frame end pulse, verdict as forward, mirror, drop
   task frm(input logic c, input logic f, input logic [13:0] l, input logic [2:0] e);
      begin
         @(posedge clk);
         rx_frame_end <= 1'b1;
         rx_crc_error <= c;
         rx_is_flow_ctrl <= f;
         rx_payload_len <= l;
         @(posedge clk);
         rx_frame_end <= 1'b0;
         @(posedge clk);
         chk({frame_forward, frame_mirror_only, frame_drop}, {29'h0, e});
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(13'h0c04, 8'h49);
      rdc(13'h1000, 8'h00);
      rdc(13'h1004, 8'h00);
      rdc(13'h0c00, 8'h50);
      rdc(13'h1ffc, 8'h00);
      chk({mode_rmii, speed_100, receive_clock_pin_oe, rx_clock_skew_enable, tx_clock_skew_enable}, 5'h1d);
      chk(receive_clock_pin_out, reduced_interface_ref_clock);
      $display("reset test done");
      for (i = 0; i < 8; i++)
      begin
         bus(1'b1, 13'h0c04, {5'h00, i[2:0]});
         chk({mode_rgmii, mode_rmii, mode_mii, speed_1000}, {i[1:0] == 2'h0, i[1:0] == 2'h1, i[1], 1'b1});
         chk({mii_clock_out_en, receive_clock_pin_oe}, {i[1] & ~i[2], i[1:0] == 2'h1 & ~i[2]});
      end
      bus(1'b1, 13'h0c04, 8'h50);
      chk({speed_1000, speed_100, speed_10, rx_clock_skew_enable, tx_clock_skew_enable}, 5'h0a);
      bus(1'b1, 13'h0c00, 8'h00);
      chk({speed_100, speed_10}, 2'h1);
      bus(1'b1, 13'h1004, 8'hff);
      rdc(13'h1004, 8'hbf);
      chk(back_pressure_active, 1'b1);
      bus(1'b1, 13'h0c00, 8'h40);
      chk(back_pressure_active, 1'b0);
      $display("mode test done");
      bus(1'b1, 13'h1000, 8'hff);
      rdc(13'h1000, 8'h0b);
      chk({storm_protect_en, max_payload}, {1'b1, 14'h2328});
      frm(1'b1, 1'b0, 14'h0040, 3'h2);
      frm(1'b0, 1'b0, 14'h002d, 3'h2);
      frm(1'b0, 1'b0, 14'h2329, 3'h2);
      frm(1'b0, 1'b0, 14'h2328, 3'h4);
      flow_ctrl_filter_en <= 1'b1;
      frm(1'b0, 1'b1, 14'h0040, 3'h1);
      bus(1'b1, 13'h1004, 8'h00);
      frm(1'b1, 1'b0, 14'h0040, 3'h1);
      flow_ctrl_filter_en <= 1'b0;
      frm(1'b0, 1'b1, 14'h0040, 3'h4);
      frame_busy <= 1'b1;
      bus(1'b1, 13'h1000, 8'h00);
      chk({storm_protect_en, max_payload}, {1'b0, 14'h2328});
      rdc(13'h13c0, 8'hcc);
      frame_busy <= 1'b0;
      repeat (3) @(posedge clk);
      chk(max_payload, 14'h05dc);
      frm(1'b0, 1'b0, 14'h05dd, 3'h1);
      $display("frame test done");
      rdc(13'h13c0, 8'h88);
      chk(link_clock_alive, 1'b1);
      run <= 1'b0;
      repeat (100) @(posedge clk);
      chk(link_clock_alive, 1'b0);
      rdc(13'h13c0, 8'h08);
      $display("link test done");
      complete_run;
   end
endmodule // switch_port_mac_interface_config_bench
`default_nettype wire
